// [verilog/srsb_map.vh]
// srsb_map.vh: constants for the spindle resync, stuck-rotor and brake controller
// assumes a 10 MHz system clock; included by bare name
`ifndef SRSB_MAP_VH
`define SRSB_MAP_VH
`define SRSB_CLK_HZ        10000000
`define SRSB_SYNC_CYC      8400000
`define SRSB_STUCK_CYC     8400000
`define SRSB_REV_MS_1      10
`define SRSB_REV_MS_2      20
`define SRSB_REV_MS_3      40
`define SRSB_ZC_WIDE       4'h7
`define SRSB_ZC_NARROW     4'h2
`define SRSB_PHASE_AB      3'h0
`define SRSB_PHASES        6
`endif

// [verilog/srsb_ctrl.v]
// srsb_ctrl.v: spindle resynchronisation, stuck-rotor timeout and brake sequencing
// assumes zero_cross and the power-loss inputs come from outside the clock domain
//
// Behaviour
// - power-on reset tristates outputs, clears control state
// - after supply ok, count crosses then resync
// - supply ok low until reset delay ends
// - resync window is 8.4 million cycles
// - activation needs supply ok, auto, run, enable
// - sequencer reference resets to phase A-B
// - crosses needed: seven or two by position
// - keep counting while disabled; resync on re-enable
// - too few crosses: start internal align and go
// - enough crosses lock sequencer, continue to lock
// - no cross in stuck time: tristate, hold
// - stuck hold left only by run toggle
// - stuck counter runs in every state
// - stuck reported as zero status bit
// - select zero: brake all three low sides
// - power-loss brake only after retract done
// - brake select not reset; host must write
// - select one: brake A and B only
// - reverse brake only while supply ok
// - reverse hands over at 10/20/40 ms interval
`timescale 1ns/1ps
`include "srsb_map.vh"
module srsb_ctrl #(
  parameter SYNC_CYC  = `SRSB_SYNC_CYC,
  parameter STUCK_CYC = `SRSB_STUCK_CYC,
  parameter MS_CYC    = `SRSB_CLK_HZ / 1000
) (
  input  wire       clock,
  input  wire       rst,               // power-on reset
  input  wire       supply_ok,         // high once the reset delay has expired
  input  wire       auto_startup_bit,
  input  wire       run_bit,
  input  wire       spin_enable_bit,
  input  wire       sequencer_reset_bit,
  input  wire       brake_phase_sel,   // 1 = two-phase brake
  input  wire       reverse_brake_bit,
  input  wire       loop_disconnect_bit,
  input  wire       power_loss,        // async pin
  input  wire       retract_done,      // async pin
  input  wire       zero_cross,        // async comparator output
  output reg        outputs_enable,    // 0 = power stage tristated
  output reg  [2:0] high_side,         // a,b,c high-side drive
  output reg  [2:0] low_side,          // a,b,c low-side drive
  output reg  [2:0] phase,             // sequencer position
  output reg        align_go_start,    // internal start-up running
  output reg        resync_done,
  output reg        stuck_status_n,    // 0 = stuck rotor
  output reg        reverse_active,
  output reg        zero_cross_indicator,
  output reg        loop_disconnect
);
  // operating states
  // idle: outputs off, waiting for the four activation conditions
  // wait: listening for back-emf inside the resync window
  // run: commutating from zero crosses
  // stuk: stuck-rotor hold, left only by a run toggle
  // brk: low-side brake, rev: reversed winding current
  // algn: internal align and go start-up in progress
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_STUK = 3'h3;
  localparam ST_BRK  = 3'h4;
  localparam ST_REV  = 3'h5;
  localparam ST_ALGN = 3'h6;

  reg [2:0]  state;
  reg [1:0]  zc_sync;        // first stage read only by the second
  reg        zc_q;           // previous synced level, for edge detect
  reg [1:0]  pl_sync;
  reg [1:0]  rd_sync;
  reg [23:0] sync_cnt;       // resync window timer
  reg [23:0] stuck_cnt;      // runs in every state
  reg [23:0] zc_interval;    // cycles since last cross, saturating
  reg [3:0]  zc_seen;        // crosses since activation
  reg [3:0]  zc_need;
  reg        run_q;
  reg        en_q;
  reg        rseq_q;
  reg        rev_q;
  reg [1:0]  rev_toggles;    // reverse threshold selector
  reg        en_dropped;     // enable cleared while spinning

  wire zc_edge  = zc_sync[1] ^ zc_q;
  wire active   = supply_ok & auto_startup_bit & run_bit & spin_enable_bit;
  wire run_tog  = run_bit ^ run_q;
  // hand-over limits in cycles; 24 bits reach past 1.6 s at 10 MHz,
  // so a much faster system clock would need a wider interval timer
  localparam [23:0] REV_LIM_1 = `SRSB_REV_MS_1 * MS_CYC;
  localparam [23:0] REV_LIM_2 = `SRSB_REV_MS_2 * MS_CYC;
  localparam [23:0] REV_LIM_3 = `SRSB_REV_MS_3 * MS_CYC;
  wire [23:0] rev_limit = (rev_toggles == 2'h3) ? REV_LIM_3 :
                          (rev_toggles == 2'h2) ? REV_LIM_2 :
                                                  REV_LIM_1;

  // synchronisers for the asynchronous pins
  // no reset here: the pins keep being tracked through power-on reset,
  // which also keeps the edge detector from seeing a false cross
  always @(posedge clock) begin
    zc_sync <= {zc_sync[0], zero_cross};
    pl_sync <= {pl_sync[0], power_loss};
    rd_sync <= {rd_sync[0], retract_done};
    zc_q    <= zc_sync[1];
  end

  // brake pattern: all low sides, or a and b only
  function [2:0] brake_pat;
    input sel;
    begin
      brake_pat = sel ? 3'h3 : 3'h7;
    end
  endfunction

  // commutation pattern for a sequencer position, {high, low}
  function [5:0] commute;
    input [2:0] p;
    begin
      case (p)
        3'h0: commute = {3'h1, 3'h2};  // a-b
        3'h1: commute = {3'h1, 3'h4};  // a-c
        3'h2: commute = {3'h2, 3'h4};  // b-c
        3'h3: commute = {3'h2, 3'h1};  // b-a
        3'h4: commute = {3'h4, 3'h1};  // c-a
        default: commute = {3'h4, 3'h2}; // c-b
      endcase
    end
  endfunction

  // main control process
  // the timers and the sequencer run beside the state machine, so a
  // coasting rotor is followed even while the outputs are tristated;
  // the stuck and power-loss overrides come last so they win over
  // whatever the state branch has just scheduled
  always @(posedge clock) begin
    if (rst) begin
      state          <= ST_IDLE;
      outputs_enable <= 1'b0;
      high_side      <= 3'h0;
      low_side       <= 3'h0;
      phase          <= `SRSB_PHASE_AB;
      align_go_start <= 1'b0;
      resync_done    <= 1'b0;
      stuck_status_n <= 1'b1;
      reverse_active <= 1'b0;
      zero_cross_indicator <= 1'b0;
      loop_disconnect <= 1'b0;
      sync_cnt       <= 24'h0;
      stuck_cnt      <= 24'h0;
      zc_interval    <= 24'h0;
      zc_seen        <= 4'h0;
      zc_need        <= 4'h0;
      run_q          <= 1'b0;
      en_q           <= 1'b0;
      rseq_q         <= 1'b0;
      rev_q          <= 1'b0;
      rev_toggles    <= 2'h0;
      en_dropped     <= 1'b0;
      // brake select has no flop here: it is held by the host side
    end else begin
      run_q  <= run_bit;
      en_q   <= spin_enable_bit;
      rseq_q <= sequencer_reset_bit;
      rev_q  <= reverse_brake_bit;
      loop_disconnect <= loop_disconnect_bit;  // host sets before reverse
      if (zc_edge)
        zero_cross_indicator <= ~zero_cross_indicator;
      // interval and stuck timers restart on every cross
      if (zc_edge) begin
        stuck_cnt   <= 24'h0;
        zc_interval <= 24'h0;
      end else begin
        if (stuck_cnt != 24'hffffff)
          stuck_cnt <= stuck_cnt + 24'h1;
        if (zc_interval != 24'hffffff)
          zc_interval <= zc_interval + 24'h1;
      end
      // sequencer reset by toggle
      if (sequencer_reset_bit ^ rseq_q)
        phase <= `SRSB_PHASE_AB;
      else if (zc_edge)
        phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      // reverse toggles pick the hand-over interval
      if (reverse_brake_bit ^ rev_q)
        rev_toggles <= (rev_toggles == 2'h3) ? 2'h3 : rev_toggles + 2'h1;
      // note enable dropped while spinning
      if (en_q & ~spin_enable_bit & (state == ST_RUN))
        en_dropped <= 1'b1;

      case (state)
        ST_IDLE: begin
          outputs_enable <= 1'b0;
          high_side      <= 3'h0;
          low_side       <= 3'h0;
          sync_cnt       <= 24'h0;
          zc_seen        <= 4'h0;
          // needed crosses from position at activation
          // position zero is the reference position A-B itself, so the long count applies
          zc_need <= (phase == 3'h0) ? `SRSB_ZC_WIDE : `SRSB_ZC_NARROW;
          if (active)
            state <= ST_WAIT;
        end
        ST_WAIT: begin
          // outputs stay off while listening for back-emf
          if (zc_edge)
            zc_seen <= zc_seen + 4'h1;
          sync_cnt <= sync_cnt + 24'h1;
          if (!active) begin
            state <= ST_IDLE;                    // host took over
          end else if (zc_edge && (zc_seen + 4'h1 >= zc_need)) begin
            state          <= ST_RUN;
            resync_done    <= 1'b1;
            outputs_enable <= 1'b1;
          end else if (sync_cnt >= SYNC_CYC - 1) begin
            state          <= ST_ALGN;
            align_go_start <= 1'b1;
            outputs_enable <= 1'b1;
          end
        end
        ST_ALGN: begin
          // drive the current position until the rotor answers with a cross;
          // the stuck timer guards this state as well
          {high_side, low_side} <= commute(phase);
          if (zc_edge) begin
            state          <= ST_RUN;
            align_go_start <= 1'b0;
          end
        end
        ST_RUN: begin
          // commutate; enable drop keeps counting, resume at next cross
          if (!spin_enable_bit) begin
            outputs_enable <= 1'b0;
            high_side      <= 3'h0;
            low_side       <= 3'h0;
          end else if (!en_dropped || zc_edge) begin
            en_dropped     <= 1'b0;
            outputs_enable <= 1'b1;
            {high_side, low_side} <= commute(phase);
          end
          if (reverse_brake_bit & supply_ok) begin
            state          <= ST_REV;
            reverse_active <= 1'b1;
          end else if (!run_bit) begin
            state <= ST_BRK;
          end
        end
        ST_REV: begin
          // reversed winding current: swap high and low of the pattern
          {low_side, high_side} <= commute(phase);
          if (!supply_ok || zc_interval >= rev_limit) begin
            state          <= ST_BRK;
            reverse_active <= 1'b0;
          end
        end
        ST_BRK: begin
          // brake holds while run is low; run back high re-enters the window
          outputs_enable <= 1'b1;
          high_side      <= 3'h0;
          low_side       <= brake_pat(brake_phase_sel);
          if (run_bit & supply_ok)
            state <= ST_IDLE;
        end
        ST_STUK: begin
          outputs_enable <= 1'b0;
          high_side      <= 3'h0;
          low_side       <= 3'h0;
          if (run_tog) begin
            state          <= ST_IDLE;
            stuck_status_n <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase

      // stuck timeout overrides the run and align states
      if (stuck_cnt >= STUCK_CYC - 1 && !zc_edge &&
          (state == ST_RUN || state == ST_ALGN)) begin
        state          <= ST_STUK;
        stuck_status_n <= 1'b0;
        outputs_enable <= 1'b0;
        align_go_start <= 1'b0;
      end
      // power loss: brake only after retract finished
      if (pl_sync[1]) begin
        if (rd_sync[1] && state != ST_STUK) begin
          state          <= ST_BRK;
          reverse_active <= 1'b0;
        end else if (!rd_sync[1]) begin
          outputs_enable <= 1'b0;
          high_side      <= 3'h0;
          low_side       <= 3'h0;
        end
      end
    end
  end
endmodule

// [test/srsb_ctrl_monitor.sv]
// srsb_ctrl_monitor.sv: port assertions for the spindle resync, stuck and brake controller
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module srsb_ctrl_monitor #(
  parameter SYNC_CYC  = 8400000,
  parameter STUCK_CYC = 8400000
) (
  input wire       clock, rst, supply_ok, auto_startup_bit, run_bit, spin_enable_bit,
  input wire       brake_phase_sel, reverse_brake_bit, outputs_enable, align_go_start,
  input wire       resync_done, stuck_status_n, reverse_active, zero_cross_indicator,
  input wire [2:0] high_side, low_side, phase
);
  wire       act = supply_ok & auto_startup_bit & run_bit & spin_enable_bit; // activated
  reg [31:0] quiet_cnt; // cycles since the last seen cross
  reg [31:0] act_cnt;   // cycles since activation
  reg [7:0]  run_age;   // cycles since run last changed, saturating
  // helper counters; margins of a few cycles absorb the pin synchroniser
  always @(posedge clock) begin
    if (rst) begin
      quiet_cnt <= 32'h0;
      act_cnt   <= 32'h0;
      run_age   <= 8'hff;
    end else begin
      quiet_cnt <= $changed(zero_cross_indicator) ? 32'h0 : quiet_cnt + 32'h1;
      act_cnt   <= act ? act_cnt + 32'h1 : 32'h0;
      run_age   <= $changed(run_bit) ? 8'h0 : (run_age == 8'hff ? run_age : run_age + 8'h1);
    end
  end
  // reset itself is the antecedent, so no disable here
  reset_tristate_a: assert property (@(posedge clock) rst |=> !outputs_enable && stuck_status_n && phase == 3'h0) else $error("outputs not idle after reset");
  activation_gate_a: assert property (@(posedge clock) disable iff (rst) $rose(resync_done) |-> $past(act)) else $error("resync without activation");
  resync_drive_a: assert property (@(posedge clock) disable iff (rst) $rose(resync_done) |-> outputs_enable && !align_go_start) else $error("resync left outputs off");
  sync_window_a: assert property (@(posedge clock) disable iff (rst) $rose(align_go_start) |-> act_cnt >= SYNC_CYC - 4) else $error("start-up before window end");
  stuck_tristate_a: assert property (@(posedge clock) disable iff (rst) !stuck_status_n |-> !outputs_enable) else $error("stuck rotor still driven");
  stuck_timer_a: assert property (@(posedge clock) disable iff (rst) $fell(stuck_status_n) |-> quiet_cnt >= STUCK_CYC - 4) else $error("stuck declared too early");
  run_toggle_a: assert property (@(posedge clock) disable iff (rst) $rose(stuck_status_n) |-> run_age <= 8'h4) else $error("stuck left without run toggle");
  brake_pattern_a: assert property (@(posedge clock) disable iff (rst) $fell(run_bit) && outputs_enable && !reverse_brake_bit && !reverse_active |-> ##2 low_side == (brake_phase_sel ? 3'h3 : 3'h7) && high_side == 3'h0) else $error("wrong brake pattern");
  reverse_supply_a: assert property (@(posedge clock) disable iff (rst) $rose(reverse_active) |-> $past(supply_ok)) else $error("reverse brake without supply");
endmodule
bind srsb_ctrl srsb_ctrl_monitor #(.SYNC_CYC(SYNC_CYC), .STUCK_CYC(STUCK_CYC)) mon_u (
  .clock(clock), .rst(rst), .supply_ok(supply_ok), .auto_startup_bit(auto_startup_bit),
  .run_bit(run_bit), .spin_enable_bit(spin_enable_bit), .brake_phase_sel(brake_phase_sel),
  .reverse_brake_bit(reverse_brake_bit), .outputs_enable(outputs_enable),
  .align_go_start(align_go_start), .resync_done(resync_done), .stuck_status_n(stuck_status_n),
  .reverse_active(reverse_active), .zero_cross_indicator(zero_cross_indicator),
  .high_side(high_side), .low_side(low_side), .phase(phase));

// [test/srsb_motor.sv]
// srsb_motor.sv: coasting spindle as seen through its zero-cross comparator
// assumes the bench sets spin and period from the controller clock domain
`timescale 1ns/1ps
module srsb_motor (
  input  wire       clock,
  input  wire       spin,      // rotor turning
  input  wire [7:0] period,    // one less than the cycles between crosses
  output reg        zero_cross // comparator level, one edge per cross
);
  reg [7:0] age; // cycles since the last cross
  initial zero_cross = 1'b0;
  initial age = 8'h0;
  // a stalled rotor freezes the comparator, so no edges reach the controller
  always @(posedge clock) begin
    if (spin && age >= period) begin
      zero_cross <= ~zero_cross;
      age        <= 8'h0;
    end else begin
      age <= (age == 8'hff) ? age : age + 8'h1;
    end
  end
endmodule

// [test/srsb_ctrl_test.sv]
// srsb_ctrl_test.sv: self-checking bench for the spindle resync, stuck and brake controller
// assumes srsb_motor drives the comparator pin; the power-loss pins stay idle
`timescale 1ns/1ps
module srsb_ctrl_test;
  localparam SYNC = 600; // shortened window, still above seven slowest crosses
  typedef struct {int code; logic [2:0] val;} srsb_note_t;
  reg        clock, rst, supply_ok, auto_startup_bit, run_bit, spin_enable_bit, spin;
  reg        sequencer_reset_bit, brake_phase_sel, reverse_brake_bit, loop_disconnect_bit;
  reg  [7:0] period;  // motor cross spacing
  wire       zero_cross, outputs_enable, align_go_start, resync_done, stuck_status_n;
  wire       reverse_active, zero_cross_indicator, loop_disconnect;
  wire [2:0] high_side, low_side, phase;
  int        n_errors = 0, check_count = 0, cyc = 0;
  srsb_note_t notes[$]; // expected results, oldest first
  event      note_ev;
  srsb_ctrl #(.SYNC_CYC(SYNC), .STUCK_CYC(SYNC), .MS_CYC(10)) dut_u (.clock(clock), .rst(rst),
    .supply_ok(supply_ok), .auto_startup_bit(auto_startup_bit), .run_bit(run_bit),
    .spin_enable_bit(spin_enable_bit), .sequencer_reset_bit(sequencer_reset_bit),
    .brake_phase_sel(brake_phase_sel), .reverse_brake_bit(reverse_brake_bit),
    .loop_disconnect_bit(loop_disconnect_bit), .power_loss(1'b0), .retract_done(1'b0),
    .zero_cross(zero_cross), .outputs_enable(outputs_enable), .high_side(high_side),
    .low_side(low_side), .phase(phase), .align_go_start(align_go_start),
    .resync_done(resync_done), .stuck_status_n(stuck_status_n), .reverse_active(reverse_active),
    .zero_cross_indicator(zero_cross_indicator), .loop_disconnect(loop_disconnect));
  srsb_motor motor_u (.clock(clock), .spin(spin), .period(period), .zero_cross(zero_cross));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // pick one observed output by code
  function automatic logic [2:0] srsb_act(input int code);
    case (code)
      0: return {2'h0, outputs_enable};
      1: return {2'h0, stuck_status_n};
      2: return phase;
      3: return {2'h0, resync_done};
      4: return {2'h0, align_go_start};
      5: return low_side;
      6: return high_side;
      7: return {2'h0, reverse_active};
      default: return {2'h0, loop_disconnect};
    endcase
  endfunction
  task note(input int code, input logic [2:0] val);
    notes.push_back('{code, val});
    ->note_ev;
  endtask
  task cycles(input int k);
    repeat (k) @(negedge clock);
  endtask
  // bounded wait; a miss shows up in the following note
  task wait_for(input int code, input logic [2:0] val, input int lim);
    for (int i = 0; i < lim && srsb_act(code) !== val; i++) @(negedge clock);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watcher: takes every queued note off the queue, oldest first, and compares it
  initial forever begin
    srsb_note_t n;
    @(note_ev);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check_count++;
      if (srsb_act(n.code) !== n.val) begin
        n_errors++;
        $display("[ERR] %0t output %0d is %h, expected %h", $time, n.code, srsb_act(n.code), n.val);
      end
    end
  end
  // hang guard, well above the expected few thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    {rst, supply_ok, auto_startup_bit, run_bit, spin_enable_bit, spin} = 6'h20;
    {sequencer_reset_bit, brake_phase_sel, reverse_brake_bit, loop_disconnect_bit} = 4'h0;
    void'($urandom(32'heb70));
    period = 8'd24 + 8'($urandom_range(40));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    brake_phase_sel <= 1'b0; // host writes the undefined select
    loop_disconnect_bit <= 1'($urandom);
    @(posedge clock);
    reverse_brake_bit <= 1'b1; // refused without supply
    sequencer_reset_bit <= 1'b1;
    cycles(4);
    note(0, 3'h0);
    note(1, 3'h1);
    note(2, 3'h0);
    note(7, 3'h0);
    note(8, {2'h0, loop_disconnect_bit});
    $display("test reset_state done");
    @(posedge clock);
    reverse_brake_bit <= 1'b0;
    spin <= 1'b1;
    @(zero_cross_indicator);
    @(posedge clock);
    sequencer_reset_bit <= 1'b0; // reference back to phase A-B
    @(posedge clock);
    {supply_ok, auto_startup_bit, run_bit, spin_enable_bit} <= 4'hf;
    repeat (6) @(zero_cross_indicator);
    cycles(2);
    note(3, 3'h0);
    @(zero_cross_indicator);
    wait_for(3, 3'h1, 20);
    note(3, 3'h1);
    note(0, 3'h1);
    note(4, 3'h0);
    // enable dropped just after a cross, resumed before the next one
    @(zero_cross_indicator);
    @(posedge clock);
    spin_enable_bit <= 1'b0;
    cycles(4);
    note(0, 3'h0);
    @(posedge clock);
    spin_enable_bit <= 1'b1;
    cycles(2);
    note(0, 3'h0);
    @(zero_cross_indicator);
    cycles(2);
    note(0, 3'h1);
    $display("test resync done");
    @(posedge clock);
    run_bit <= 1'b0;
    cycles(4);
    note(5, 3'h7);
    note(6, 3'h0);
    @(posedge clock);
    brake_phase_sel <= 1'b1;
    cycles(4);
    note(5, 3'h3);
    $display("test brake done");
    // back to run through a fresh window, then reverse with three toggles
    @(posedge clock);
    run_bit <= 1'b1;
    cycles(3);
    wait_for(0, 3'h1, SYNC + 50);
    note(3, 3'h1);
    @(posedge clock);
    reverse_brake_bit <= 1'b1;
    cycles(4);
    note(7, 3'h1);
    @(posedge clock);
    spin <= 1'b0;
    run_bit <= 1'b0;
    cycles(300);
    note(7, 3'h1);
    wait_for(7, 3'h0, 200);
    note(7, 3'h0);
    cycles(2);
    note(5, 3'h3);
    note(6, 3'h0);
    $display("test reverse done");
    @(posedge clock);
    rst <= 1'b1; // second reset in mid-run, rotor now stopped
    spin <= 1'b0;
    run_bit <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wait_for(4, 3'h1, SYNC + 50);
    note(4, 3'h1);
    note(3, 3'h0);
    wait_for(1, 3'h0, SYNC + 50);
    note(1, 3'h0);
    note(0, 3'h0);
    cycles(20);
    note(1, 3'h0);
    @(posedge clock);
    run_bit <= 1'b0;
    cycles(4);
    note(1, 3'h1);
    $display("test window_stuck done");
    cycles(2);
    test_done;
  end
endmodule
